// *** verilog/sysclk_ctrl.sv ***
// System clock, PLL settle and power mode controller with APB registers
//
// What this block does
// - PLL powered down after reset until enabled
// - PLL output halved before system divider
// - Crystal number translated, readable as settings
// - Crystal change relocks; same value does not
// - Extended source seven selects real-time reference
// - Normal mode drives output, power-down does not
// - Relock on crystal change or power-up
// - Oscillator-clocked down counter loaded, expiry means stable
// - Stay on oscillator until PLL settles
// - Raw lock flag plus maskable lock interrupt
// - Run mode gates peripherals by run bits
// - Sleep modes stop core, auto-gating picks bits
// - Deep-sleep source main or chosen internal oscillator
// - Deep-sleep entry with PLL on stops it, overrides divider
// - Exit restores clock before reopening gates
// - Wait-for-interrupt enters sleep, interrupt wakes
// - Extended fields win when extended use set
// - Clearing power-down powers PLL and output
// - Extended encodings applied instead of basic
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module sysclk_ctrl
  import sysclk_pkg::*;
#(
  parameter logic [15:0] SETTLE_TICKS = SETTLE_TICKS_DEF
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        mosc_clk,
  input  wire logic                        wait_for_interrupt,
  input  wire logic                        deep_sleep_en,
  input  wire logic                        wake_irq,
  output logic                             pll_power_down,
  output logic      [13:0]                 pll_settings,
  output logic                             pll_ref_rtc,
  output logic                             pll_lock,
  output logic                             sysclk_use_pll,
  output logic      [2:0]                  sysclk_src,
  output logic      [7:0]                  sysclk_div,
  output logic                             cpu_clk_en,
  output logic      [32*NUM_GATE_REGS-1:0] periph_clk_en,
  output logic                             main_osc_pd,
  output logic                             int_osc_pu,
  output logic                             lock_irq
);

  ////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    mode_e                             mode;
    logic [31:0]                       rcfg;
    logic [31:0]                       xcfg;
    logic [31:0]                       dcfg;
    logic [NUM_GATE_REGS-1:0][31:0]    rg;
    logic [NUM_GATE_REGS-1:0][31:0]    sg;
    logic [NUM_GATE_REGS-1:0][31:0]    dg;
    logic                              imask;
    logic                              flag;
    logic [15:0]                       cnt;
    logic                              lock;
    logic                              ms1;
    logic                              ms2;
    logic                              ms3;
    logic                              ds_pll;
    logic [31:0]                       prdata;
    logic                              pready;
    logic                              pslverr;
    logic                              pll_pd;
    logic [13:0]                       pll_set;
    logic                              rtc;
    logic                              use_pll;
    logic [2:0]                        src;
    logic [7:0]                        div;
    logic                              cpu_en;
    logic [32*NUM_GATE_REGS-1:0]       pen;
    logic                              mosc_pd;
    logic                              iosc_pu;
    logic                              irq;
  } st_s;

  st_s q;
  st_s d;

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Crystal number to PLL feedback and reference settings
  function automatic logic [13:0] pll_xlate(input logic [3:0] xsel,
                                            input logic       rtc);
    logic [8:0] fb;
    logic [4:0] rf;
    fb = 9'h0C8 - {2'b00, xsel, 3'b000};
    rf = {1'b0, xsel} + 5'h01;
    if (rtc) begin
      fb = 9'h1FF;
      rf = 5'h00;
    end
    return {fb, rf};
  endfunction

  // Gating word index from an offset inside a gating group
  function automatic int gate_idx(input logic [11:0] a);
    return int'(a[3:2]);
  endfunction

  // True when the offset falls inside a gating group
  function automatic logic in_group(input logic [11:0] a,
                                    input logic [11:0] base);
    return (a[11:4] == base[11:4]) && (a[3:2] < 2'(NUM_GATE_REGS));
  endfunction

  logic                          tick;
  logic                          wr;
  logic                          use_x;
  logic                          eff_pd;
  logic                          eff_byp;
  logic [2:0]                    eff_src;
  logic [5:0]                    eff_div;
  logic                          pll_off;
  logic                          xsel_chg;
  logic                          trig;
  logic                          ds;
  logic                          ds_int;
  logic [5:0]                    div_sel;
  logic [7:0]                    div_base;
  logic                          ovr;
  logic [NUM_GATE_REGS-1:0][31:0] gsel;
  logic [31:0]                   rdat;
  logic                          hit;

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    // Two-stage capture of the oscillator pin, then edge detect
    d.ms1 = mosc_clk;
    d.ms2 = q.ms1;
    d.ms3 = q.ms2;
    tick  = q.ms2 & ~q.ms3;
    wr    = psel & penable & q.pready & pwrite;

    // Extended fields override the basic ones when selected
    use_x   = q.xcfg[F_X_USE];
    eff_pd  = use_x ? q.xcfg[F_PWR_DN] : q.rcfg[F_PWR_DN];
    eff_byp = use_x ? q.xcfg[F_BYPASS] : q.rcfg[F_BYPASS];
    eff_src = use_x ? q.xcfg[F_X_OSC_LSB +: 3]
                    : {1'b0, q.rcfg[F_OSC_LSB +: 2]};
    eff_div = use_x ? q.xcfg[F_DIV_LSB +: 6]
                    : {2'b00, q.rcfg[F_DIV_LSB +: 4]};
    ds      = (q.mode == M_DSLEEP);
    ds_int  = ds & (q.dcfg[F_DS_OSC_LSB +: 3] != 3'h0);
    // PLL held off by its own bit or by deep-sleep override
    pll_off = eff_pd | (ds & q.ds_pll);

    // Relock on a real crystal change or on leaving power-down
    xsel_chg = wr & (paddr == OFS_RUN_CFG) &
               (pwdata[F_XSEL_LSB +: 4] != q.rcfg[F_XSEL_LSB +: 4]);
    trig     = xsel_chg | (q.pll_pd & ~pll_off);

    // APB read mux, sampled in the setup cycle
    rdat = 32'h0000_0000;
    hit  = 1'b1;
    if (in_group(paddr, OFS_RUN_GATE)) begin
      rdat = q.rg[gate_idx(paddr)];
    end else if (in_group(paddr, OFS_SLEEP_GATE)) begin
      rdat = q.sg[gate_idx(paddr)];
    end else if (in_group(paddr, OFS_DS_GATE)) begin
      rdat = q.dg[gate_idx(paddr)];
    end else begin
      case (paddr)
        OFS_RAW_FLAGS:   rdat[F_LOCK_BIT] = q.flag;
        OFS_INT_MASK:    rdat[F_LOCK_BIT] = q.imask;
        OFS_MASKED:      rdat[F_LOCK_BIT] = q.flag & q.imask;
        OFS_RUN_CFG:     rdat = q.rcfg;
        OFS_XLATE:       rdat = {18'h0_0000, q.pll_set};
        OFS_RUN_CFG_EXT: rdat = q.xcfg;
        OFS_DS_CFG:      rdat = q.dcfg;
        default:         hit = 1'b0;
      endcase
    end
    // Zero-wait answer: ready rises in the access cycle
    d.pready  = psel & ~penable;
    d.prdata  = (psel & ~penable) ? rdat : 32'h0000_0000;
    d.pslverr = psel & ~penable & ~hit;

    // Register writes at the access edge; read-only words ignore them
    if (wr) begin
      if (in_group(paddr, OFS_RUN_GATE)) begin
        d.rg[gate_idx(paddr)] = pwdata;
      end else if (in_group(paddr, OFS_SLEEP_GATE)) begin
        d.sg[gate_idx(paddr)] = pwdata;
      end else if (in_group(paddr, OFS_DS_GATE)) begin
        d.dg[gate_idx(paddr)] = pwdata;
      end else begin
        case (paddr)
          OFS_INT_MASK:    d.imask = pwdata[F_LOCK_BIT];
          OFS_MASKED: begin
            if (pwdata[F_LOCK_BIT]) begin
              d.flag = 1'b0;
            end
          end
          OFS_RUN_CFG:     d.rcfg = pwdata;
          OFS_RUN_CFG_EXT: d.xcfg = pwdata;
          OFS_DS_CFG:      d.dcfg = pwdata;
          default:         d.rcfg = q.rcfg;
        endcase
      end
    end

    // Settle counter; a retrigger mid-count starts over
    if (trig) begin
      d.cnt  = SETTLE_TICKS;
      d.lock = 1'b0;
      d.flag = 1'b0;
    end else begin
      if (tick && (q.cnt != 16'h0000)) begin
        d.cnt = q.cnt - 16'h0001;
      end
      d.lock = (q.cnt == 16'h0000) & ~pll_off;
    end
    // Lock event beats a software clear in the same cycle
    if (d.lock & ~q.lock) begin
      d.flag = 1'b1;
    end
    d.irq = d.flag & d.imask;

    // Mode sequencing driven by the core
    case (q.mode)
      M_RUN: begin
        if (wait_for_interrupt) begin
          d.mode   = deep_sleep_en ? M_DSLEEP : M_SLEEP;
          d.ds_pll = deep_sleep_en & ~eff_pd;
        end
      end
      M_SLEEP: begin
        if (wake_irq) begin
          d.mode = M_RUN;
        end
      end
      M_DSLEEP: begin
        if (wake_irq) begin
          d.mode = M_RESTORE;
        end
      end
      M_RESTORE: begin
        // Gates stay closed until the pre-sleep clock is back
        if (~q.ds_pll | q.lock | eff_byp) begin
          d.mode   = M_RUN;
          d.ds_pll = 1'b0;
        end
      end
      default: d.mode = M_RUN;
    endcase

    // PLL control outputs
    d.pll_pd  = pll_off;
    d.rtc     = use_x & (q.xcfg[F_X_OSC_LSB +: 3] == RTC_SOURCE);
    d.pll_set = pll_xlate(q.rcfg[F_XSEL_LSB +: 4], d.rtc);

    // System clock: oscillator until the PLL has settled
    d.use_pll = ~eff_byp & q.lock & ~pll_off;
    d.src     = ds ? q.dcfg[F_DS_OSC_LSB +: 3] : eff_src;
    ovr       = ds & q.ds_pll;
    div_sel   = ovr ? q.dcfg[F_DS_DIV_LSB +: 6] : eff_div;
    div_base  = (ovr | q.rcfg[F_USE_DIV]) ? ({2'b00, div_sel} + 8'h01)
                                          : 8'h01;
    // The PLL path always carries the fixed halving
    d.div     = d.use_pll ? 8'(div_base * PLL_PRE_DIV) : div_base;

    // Oscillator power: internal one replaces main in deep sleep when the deep-sleep source is not zero
    d.mosc_pd = ds_int | (~ds & q.rcfg[F_MOSC_DIS]);
    d.iosc_pu = ds_int | ~q.rcfg[F_IOSC_DIS];

    // Core and peripheral gating per mode
    d.cpu_en = (d.mode == M_RUN);
    gsel     = q.rg;
    if ((q.mode == M_SLEEP) && q.rcfg[F_AUTO_GATE]) begin
      gsel = q.sg;
    end else if (((q.mode == M_DSLEEP) || (q.mode == M_RESTORE)) &&
                 q.rcfg[F_AUTO_GATE]) begin
      gsel = q.dg;
    end
    d.pen = gsel;
  end

  ////////////////////////////////////////////////////////////////////
  // Registers

  // Only constants under reset; every configuration bit gets a value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q         <= '0;
      q.mode    <= M_RUN;
      q.rcfg    <= RST_RUN_CFG;
      q.xcfg    <= RST_RUN_CFG_EXT;
      q.dcfg    <= RST_DS_CFG;
      q.rg      <= {RST_GATE, RST_GATE, RST_GATE0};
      q.sg      <= {RST_GATE, RST_GATE, RST_GATE0};
      q.dg      <= {RST_GATE, RST_GATE, RST_GATE0};
      // Gates open as the reset gating words say, so no step follows reset
      q.pen     <= {RST_GATE, RST_GATE, RST_GATE0};
      q.pll_pd  <= 1'b1;
      q.div     <= 8'h01;
      q.cpu_en  <= 1'b1;
      q.iosc_pu <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state flops
  assign prdata         = q.prdata;
  assign pready         = q.pready;
  assign pslverr        = q.pslverr;
  assign pll_power_down = q.pll_pd;
  assign pll_settings   = q.pll_set;
  assign pll_ref_rtc    = q.rtc;
  assign pll_lock       = q.lock;
  assign sysclk_use_pll = q.use_pll;
  assign sysclk_src     = q.src;
  assign sysclk_div     = q.div;
  assign cpu_clk_en     = q.cpu_en;
  assign periph_clk_en  = q.pen;
  assign main_osc_pd    = q.mosc_pd;
  assign int_osc_pu     = q.iosc_pu;
  assign lock_irq       = q.irq;

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_PD_FOLLOWS: assert property (
    eff_pd |=> pll_power_down && !pll_lock)
    else $error("PLL not held off while power-down set");

  AST_RELOCK_LOAD: assert property (
    trig |=> (q.cnt == SETTLE_TICKS) && !pll_lock)
    else $error("Settle counter not reloaded on trigger");

  AST_SAME_CRYSTAL: assert property (
    (wr && paddr == OFS_RUN_CFG && !pll_power_down && !trig
     && pwdata[F_XSEL_LSB +: 4] == q.rcfg[F_XSEL_LSB +: 4]
     && pll_lock && !eff_pd) |=> pll_lock)
    else $error("Same crystal value caused a relock");

  AST_LOCK_ONLY_EXPIRED: assert property (
    $rose(pll_lock) |-> $past(q.cnt) == 16'h0000)
    else $error("Lock before counter expiry");

  AST_OSC_UNTIL_LOCK: assert property (
    !pll_lock |=> !sysclk_use_pll)
    else $error("System clock on PLL before it settled");

  AST_RTC_REF: assert property (
    (use_x && q.xcfg[F_X_OSC_LSB +: 3] == RTC_SOURCE) |=> pll_ref_rtc)
    else $error("Real-time reference not selected");

  AST_IRQ_MASK: assert property (
    $rose(pll_lock) && q.imask && !wr |-> ##1 lock_irq)
    else $error("Lock interrupt missing");

  AST_CORE_STOP: assert property (
    (q.mode != M_RUN) |-> !cpu_clk_en)
    else $error("Core clock running in a sleep mode");

  AST_RUN_GATE: assert property (
    (q.mode == M_RUN) ##1 (q.mode == M_RUN) |-> periph_clk_en == $past(q.rg))
    else $error("Run gating not applied");

  AST_DS_PLL_OFF: assert property (
    (q.mode == M_DSLEEP && q.ds_pll) |=> pll_power_down)
    else $error("PLL left running in deep sleep");

  AST_WAKE: assert property (
    (q.mode == M_SLEEP && wake_irq) |=> (q.mode == M_RUN) && cpu_clk_en)
    else $error("Sleep not left on interrupt");

  AST_RESTORE_ORDER: assert property (
    (q.mode == M_DSLEEP && wake_irq) |=> (q.mode == M_RESTORE) && !cpu_clk_en)
    else $error("Clocks reopened before clock restore");

endmodule

// *** verilog/sysclk_pkg.sv ***
// Constants, field layout and mode type of the system clock controller
package sysclk_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_RAW_FLAGS   = 12'h050;
  localparam logic [11:0] OFS_INT_MASK    = 12'h054;
  localparam logic [11:0] OFS_MASKED      = 12'h058;
  localparam logic [11:0] OFS_RUN_CFG     = 12'h060;
  localparam logic [11:0] OFS_XLATE       = 12'h064;
  localparam logic [11:0] OFS_RUN_CFG_EXT = 12'h070;
  localparam logic [11:0] OFS_RUN_GATE    = 12'h100;
  localparam logic [11:0] OFS_SLEEP_GATE  = 12'h110;
  localparam logic [11:0] OFS_DS_GATE     = 12'h120;
  localparam logic [11:0] OFS_DS_CFG      = 12'h144;
  // Values after reset
  localparam logic [31:0] RST_RUN_CFG     = 32'h078E_3AD1;
  localparam logic [31:0] RST_RUN_CFG_EXT = 32'h0780_2810;
  localparam logic [31:0] RST_DS_CFG      = 32'h0780_0000;
  localparam logic [31:0] RST_GATE0       = 32'h0000_0040;
  localparam logic [31:0] RST_GATE        = 32'h0000_0000;
  // Field positions in the run configuration word
  localparam int F_MOSC_DIS  = 0;
  localparam int F_IOSC_DIS  = 1;
  localparam int F_OSC_LSB   = 4;
  localparam int F_XSEL_LSB  = 6;
  localparam int F_BYPASS    = 11;
  localparam int F_PWR_DN    = 13;
  localparam int F_USE_DIV   = 22;
  localparam int F_DIV_LSB   = 23;
  localparam int F_AUTO_GATE = 27;
  // Field positions in the extended and deep-sleep words
  localparam int F_X_USE      = 31;
  localparam int F_X_OSC_LSB  = 4;
  localparam int F_DS_OSC_LSB = 4;
  localparam int F_DS_DIV_LSB = 23;
  // Lock flag position in the flag registers
  localparam int F_LOCK_BIT = 6;
  // Extended source code that selects the real-time oscillator
  localparam logic [2:0] RTC_SOURCE = 3'h7;
  // Main oscillator ticks of the settle count
  localparam logic [15:0] SETTLE_TICKS_DEF = 16'h1200;
  // Fixed division of the PLL output ahead of the system divider
  localparam logic [7:0] PLL_PRE_DIV = 8'h02;
  // Number of gating words per mode
  localparam int NUM_GATE_REGS = 3;
  // Power modes
  typedef enum logic [1:0] {M_RUN, M_SLEEP, M_DSLEEP, M_RESTORE} mode_e;
endpackage

// *** tb/core_osc_model.sv ***
// Core and main oscillator model on the far side of the clock controller
`timescale 1ns/1ps
module core_osc_model (
  input  wire logic pclk,
  output logic      mosc_clk,
  output logic      wait_for_interrupt,
  output logic      deep_sleep_en,
  output logic      wake_irq
);
  // Free-running oscillator; slower than pclk/2 so every edge survives the synchroniser
  initial begin
    mosc_clk = 1'b0;
    #37;
    forever #185 mosc_clk = ~mosc_clk;
  end
  // Core lines idle after power-up
  initial begin
    wait_for_interrupt = 1'b0;
    deep_sleep_en = 1'b0;
    wake_irq      = 1'b0;
  end
  // Sleep request: deep enable level comes with the wait-for-interrupt pulse
  task automatic nap(input logic deep);
    @(posedge pclk);
    deep_sleep_en <= deep;
    wait_for_interrupt <= 1'b1;
    @(posedge pclk);
    wait_for_interrupt <= 1'b0;
  endtask
  // One-cycle wake interrupt
  task automatic wake();
    @(posedge pclk);
    wake_irq <= 1'b1;
    @(posedge pclk);
    wake_irq <= 1'b0;
  endtask
endmodule

// *** tb/pll_sysclk_power_mode_control_test.sv ***
// Self-checking bench for the system clock controller
`timescale 1ns/1ps
module pll_sysclk_power_mode_control_test;
  import sysclk_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, g0, g1, g2;
  logic        pready, pslverr, mosc_clk, wait_for_interrupt, deep_sleep_en, wake_irq;
  logic        pll_power_down, pll_ref_rtc, pll_lock, sysclk_use_pll, cpu_clk_en;
  logic        main_osc_pd, int_osc_pu, lock_irq;
  logic [13:0] pll_settings;
  logic [2:0]  sysclk_src;
  logic [7:0]  sysclk_div;
  logic [95:0] periph_clk_en;
  logic [3:0]  x, x2, dv;
  logic [5:0]  ov;
  logic [32:0] expq[$];
  int          errors, n_tests, n, i;
  localparam logic [11:0] RA[8] = '{OFS_RUN_CFG, OFS_RUN_CFG_EXT, OFS_DS_CFG, OFS_RUN_GATE,
    OFS_RUN_GATE + 12'h004, OFS_SLEEP_GATE, OFS_DS_GATE, 12'h200};
  localparam logic [32:0] RE[8] = '{{1'b0, RST_RUN_CFG}, {1'b0, RST_RUN_CFG_EXT},
    {1'b0, RST_DS_CFG}, {1'b0, RST_GATE0}, {1'b0, RST_GATE}, {1'b0, RST_GATE0},
    {1'b0, RST_GATE0}, {1'b1, 32'h0000_0000}};

  sysclk_ctrl #(.SETTLE_TICKS(16'h0008)) sysclk_ctrl_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mosc_clk(mosc_clk), .wait_for_interrupt(wait_for_interrupt),
    .deep_sleep_en(deep_sleep_en), .wake_irq(wake_irq),
    .pll_power_down(pll_power_down), .pll_settings(pll_settings), .pll_ref_rtc(pll_ref_rtc),
    .pll_lock(pll_lock), .sysclk_use_pll(sysclk_use_pll), .sysclk_src(sysclk_src),
    .sysclk_div(sysclk_div), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .main_osc_pd(main_osc_pd), .int_osc_pu(int_osc_pu), .lock_irq(lock_irq));
  core_osc_model core_osc_model_i (
    .pclk(pclk), .mosc_clk(mosc_clk), .wait_for_interrupt(wait_for_interrupt),
    .deep_sleep_en(deep_sleep_en), .wake_irq(wake_irq));

  ////////////////////////////////////////////////////////////////////////////////
  // Expected crystal translation and run configuration word
  function automatic logic [13:0] xl(input logic [3:0] c);
    return {9'd200 - 9'(c) * 9'd8, 5'(c) + 5'd1};
  endfunction
  function automatic logic [31:0] cfg(input logic [3:0] c, input logic byp, pd, ud,
                                      input logic [3:0] d, input logic ag);
    cfg = '0;
    cfg[F_XSEL_LSB+:4] = c;
    cfg[F_BYPASS] = byp;
    cfg[F_PWR_DN] = pd;
    cfg[F_USE_DIV] = ud;
    cfg[F_DIV_LSB+:4] = d;
    cfg[F_AUTO_GATE] = ag;
  endfunction

  // Clock and time-zero values
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [95:0] g, input logic [95:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Settle k edges, then sample
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask
  // APB transfer; a read leaves its expected {pslverr, prdata} in the queue
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) expq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  // Wait for lock; system clock must stay off the PLL meanwhile
  task automatic wait_lock(input logic c);
    n = 0;
    while (pll_lock !== 1'b1 && n < 300) begin
      chk(sysclk_use_pll, 1'b0);
      chk(cpu_clk_en, c);
      cyc(1);
      n++;
    end
  endtask

  // Read-data watcher: oldest note against each completed read
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      n_tests++;
      if (expq.size() == 0 || {pslverr, prdata} !== expq[0]) begin
        errors++;
        $display("[FAIL] %0t got %h exp %h", $time, {pslverr, prdata}, expq[0]);
      end
      if (expq.size() != 0) void'(expq.pop_front());
    end
  end

  // A hang counts as a mismatch
  initial begin
    #2_000_000;
    errors++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, errors, n_tests} = '0;
    presetn = 1'b0;
    void'($urandom(92347));
    x = 4'($urandom);
    if (x == 4'hB) x = 4'h3;
    x2 = x ^ 4'h5;
    dv = 4'($urandom);
    ov = 6'($urandom);
    g0 = $urandom;
    g1 = $urandom;
    g2 = $urandom;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    cyc(1);
    for (i = 0; i < 8; i++) apb(1'b0, RA[i], '0, RE[i]);
    apb(1'b1, OFS_XLATE, 32'hFFFF_FFFF, '0);
    apb(1'b0, OFS_XLATE, '0, {19'h0_0000, xl(4'hB)});
    chk(pll_power_down, 1'b1);
    // Extended fields: real-time reference
    apb(1'b1, OFS_RUN_CFG_EXT, 32'h8000_2070, '0);
    cyc(2);
    chk(pll_ref_rtc, 1'b1);
    chk(pll_settings, {9'h1FF, 5'h00});
    apb(1'b1, OFS_RUN_CFG_EXT, RST_RUN_CFG_EXT, '0);
    cyc(2);
    chk(pll_ref_rtc, 1'b0);
    // Software switch sequence; the retrigger must restart the full count
    apb(1'b1, OFS_RUN_CFG, cfg(4'hB, 1'b1, 1'b1, 1'b0, 4'h0, 1'b0), '0);
    apb(1'b1, OFS_RUN_CFG, cfg(x, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0), '0);
    cyc(2);
    chk(pll_power_down, 1'b0);
    chk(pll_settings, xl(x));
    cyc(12);
    chk(pll_lock, 1'b0);
    apb(1'b1, OFS_RUN_CFG, cfg(x2, 1'b1, 1'b0, 1'b1, dv, 1'b0), '0);
    wait_lock(1'b1);
    chk(n >= 25 && n <= 40, 1'b1);
    chk(pll_settings, xl(x2));
    apb(1'b0, OFS_RAW_FLAGS, '0, {1'b0, 32'h0000_0040});
    chk(lock_irq, 1'b0);
    apb(1'b1, OFS_INT_MASK, 32'h0000_0040, '0);
    apb(1'b1, OFS_RUN_CFG, cfg(x2, 1'b1, 1'b0, 1'b1, dv, 1'b0), '0);
    cyc(2);
    chk(lock_irq, 1'b1);
    chk(pll_lock, 1'b1);
    apb(1'b1, OFS_MASKED, 32'h0000_0040, '0);
    apb(1'b0, OFS_RAW_FLAGS, '0, {1'b0, 32'h0000_0000});
    // Power down, then enable and select the PLL in one write
    apb(1'b1, OFS_RUN_CFG, cfg(x2, 1'b1, 1'b1, 1'b1, dv, 1'b0), '0);
    cyc(2);
    chk({pll_power_down, pll_lock}, 2'b10);
    apb(1'b1, OFS_RUN_CFG, cfg(x2, 1'b0, 1'b0, 1'b1, dv, 1'b1), '0);
    wait_lock(1'b1);
    cyc(3);
    chk(sysclk_use_pll, 1'b1);
    chk(sysclk_div, (8'(dv) + 8'd1) * PLL_PRE_DIV);
    // Gating words and sleep modes
    apb(1'b1, OFS_RUN_GATE + 12'h004, g0, '0);
    apb(1'b1, OFS_SLEEP_GATE + 12'h004, g1, '0);
    apb(1'b1, OFS_DS_GATE + 12'h004, g2, '0);
    apb(1'b1, OFS_DS_CFG, (32'(ov) << F_DS_DIV_LSB) | 32'h0000_0010, '0);
    cyc(2);
    chk(periph_clk_en[63:32], g0);
    core_osc_model_i.nap(1'b0);
    cyc(2);
    chk({cpu_clk_en, sysclk_use_pll}, 2'b01);
    chk(periph_clk_en[63:32], g1);
    core_osc_model_i.wake();
    cyc(2);
    chk(cpu_clk_en, 1'b1);
    core_osc_model_i.nap(1'b1);
    cyc(2);
    chk({pll_power_down, sysclk_use_pll, cpu_clk_en}, 3'b100);
    chk(sysclk_div, 8'(ov) + 8'd1);
    chk({main_osc_pd, int_osc_pu, sysclk_src}, 5'b11_001);
    chk(periph_clk_en[63:32], g2);
    core_osc_model_i.wake();
    cyc(2);
    wait_lock(1'b0);
    cyc(3);
    chk({cpu_clk_en, sysclk_use_pll, main_osc_pd}, 3'b110);
    chk(sysclk_div, (8'(dv) + 8'd1) * PLL_PRE_DIV);
    chk(periph_clk_en[63:32], g0);
    report_and_stop();
  end
endmodule
